//--- dcoc_pkg.sv
// Package of constants and types for the dithered clock output control.
package dcoc_pkg;
    // Register map, byte addresses on the Avalon-MM slave.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0006;
    localparam logic [31:0] CTRL_MASK = 32'h0000_003F;
    localparam int CTRL_EXP_LSB = 0;
    localparam int CTRL_EXP_W = 4;
    localparam int CTRL_DEPTH_BIT = 4;
    localparam int CTRL_IDLE_BIT = 5;
    localparam logic [3:0] EXP_MAX = 4'h8;

    // Timing, clock at 100 MHz.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_CYC = 512;
    localparam logic [8:0] SETTLE_LAST = 9'(SETTLE_CYC - 1);
    localparam int T_STAB_US = 500;
    localparam int STAB_CYC = T_STAB_US * 1000 / CLK_PERIOD_NS;
    localparam int T_PDN_MS = 1;
    localparam int PDN_CYC = T_PDN_MS * 1000000 / CLK_PERIOD_NS;

    // Dither: triangle of 16 steps up and 16 down over 4096 cycles.
    localparam int DITHER_PERIOD = 4096;
    localparam logic [4:0] TRI_TOP = 5'h10;
    localparam int TRI_STEP_CYC = DITHER_PERIOD / (2 * 16);
    localparam logic [6:0] STEP_LAST = 7'(TRI_STEP_CYC - 1);
    localparam logic [10:0] ACC_MOD = 11'h320;

    typedef enum logic [2:0] {
        ST_PWRDN = 3'b001,
        ST_SETTLE = 3'b010,
        ST_RUN = 3'b100
    } dcoc_state_t;
endpackage

//--- dcoc_sync.sv
// Two-stage synchroniser for a group of asynchronous level pins.
`timescale 1ns/100ps
module dcoc_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

    a_sync_two_stage: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn, 2) |-> sync_o == $past(async_i, 2))
        else $error("synchroniser output is not the input two cycles late");
endmodule // dcoc_sync

//--- dcoc_top.sv
// Output gating, settling, power-down and dither for the clock generator.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module dcoc_top
    import dcoc_pkg::*;
#(
    parameter int STAB_MAX = STAB_CYC,
    parameter int PDN_MAX = PDN_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic dither_enable_pin,
    input wire logic output_enable_pin,
    input wire logic power_down_pin,
    output logic clk_out_o,
    output logic clk_out_oe,
    output logic osc_running_o
);
    localparam int CLOSE_WAIT = 300;

    logic [2:0] pins_s;
    logic dith_s;
    logic oe_s;
    logic pd_s;

    dcoc_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_i({dither_enable_pin, output_enable_pin, power_down_pin}),
        .sync_o(pins_s)
    );
    assign dith_s = pins_s[2];
    assign oe_s = pins_s[1];
    assign pd_s = pins_s[0];

    // Register slave. Every access waits exactly one cycle.
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] status;
    dcoc_state_t state_q;
    dcoc_state_t state_d;
    logic gate_q;
    logic gate_d;
    logic dith_act;
    logic osc_running;

    assign status = {26'h000_0000, osc_running, dith_act, gate_q, state_q};
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always_comb begin
        ack_d = (avs_read | avs_write) & ~ack_q;
        ctrl_d = ctrl_q;
        rdata_d = rdata_q;
        if (ack_q && avs_write && avs_address == CTRL_OFS) begin
            ctrl_d = avs_writedata & CTRL_MASK;
        end
        if (avs_read && !ack_q) begin
            if (avs_address == CTRL_OFS) begin
                rdata_d = ctrl_q;
            end else if (avs_address == STAT_OFS) begin
                rdata_d = status;
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q <= CTRL_RST;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end
    assign avs_readdata = rdata_q;

    logic [3:0] exp_raw;
    logic [3:0] exp_eff;
    logic [8:0] half_m1;
    assign exp_raw = ctrl_q[CTRL_EXP_LSB +: CTRL_EXP_W];
    assign exp_eff = (exp_raw > EXP_MAX) ? EXP_MAX : exp_raw;
    assign half_m1 = 9'((9'h001 << exp_eff) - 9'h001);

    // Oscillator state: stopped, settling, running.
    logic [8:0] settle_q;
    logic [8:0] settle_d;

    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        case (state_q)
            ST_PWRDN: begin
                if (pd_s) begin
                    state_d = ST_SETTLE;
                    settle_d = 9'h000;
                end
            end
            ST_SETTLE: begin
                if (!pd_s) begin
                    state_d = ST_PWRDN;
                end else if (settle_q == SETTLE_LAST) begin
                    state_d = ST_RUN;
                end else begin
                    settle_d = 9'(settle_q + 9'h001);
                end
            end
            ST_RUN: begin
                if (!pd_s) begin
                    state_d = ST_PWRDN;
                end
            end
            default: begin
                state_d = ST_PWRDN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= ST_PWRDN;
            settle_q <= 9'h000;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
        end
    end

    // Dither. A triangle steers a fractional accumulator; each overflow
    // stalls the divider for one cycle, so periods only ever stretch.
    logic [4:0] tri_q;
    logic [4:0] tri_d;
    logic up_q;
    logic up_d;
    logic [6:0] step_q;
    logic [6:0] step_d;
    logic [9:0] acc_q;
    logic [9:0] acc_d;
    logic [9:0] inc;
    logic [10:0] sum;
    logic stall;

    assign dith_act = (state_q == ST_RUN) & dith_s;
    assign inc = ctrl_q[CTRL_DEPTH_BIT] ? {5'h00, tri_q} : {4'h0, tri_q, 1'b0};
    assign sum = {1'b0, acc_q} + {1'b0, inc};

    always_comb begin
        tri_d = tri_q;
        up_d = up_q;
        step_d = step_q;
        acc_d = acc_q;
        stall = 1'b0;
        if (!dith_act) begin
            tri_d = 5'h00;
            up_d = 1'b1;
            step_d = 7'h00;
            acc_d = 10'h000;
        end else begin
            step_d = 7'(step_q + 7'h01);
            if (step_q == STEP_LAST) begin
                if (up_q) begin
                    up_d = (tri_q != 5'(TRI_TOP - 5'h01));
                    tri_d = 5'(tri_q + 5'h01);
                end else begin
                    up_d = (tri_q == 5'h01);
                    tri_d = 5'(tri_q - 5'h01);
                end
            end
            if (sum >= ACC_MOD) begin
                stall = 1'b1;
                acc_d = 10'(sum - ACC_MOD);
            end else begin
                acc_d = sum[9:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            tri_q <= 5'h00;
            up_q <= 1'b1;
            step_q <= 7'h00;
            acc_q <= 10'h000;
        end else begin
            tri_q <= tri_d;
            up_q <= up_d;
            step_q <= step_d;
            acc_q <= acc_d;
        end
    end

    // Output gate and divider. The gate opens with the divider cleared, so
    // the first edge comes a fixed count after the open unless a dither stall delays it, and closes
    // only in a low phase, so no runt pulse reaches the pin.
    logic want;
    logic out_q;
    logic out_d;
    logic [8:0] div_q;
    logic [8:0] div_d;
    logic oe_q;
    logic oe_d;

    assign want = (state_q == ST_RUN) & oe_s;
    assign osc_running = (state_q != ST_PWRDN) | gate_q;

    always_comb begin
        gate_d = gate_q;
        out_d = out_q;
        div_d = div_q;
        if (!gate_q) begin
            out_d = 1'b0;
            div_d = 9'h000;
            gate_d = want;
        end else if (!want && !out_q) begin
            gate_d = 1'b0;
            div_d = 9'h000;
        end else if (!stall) begin
            if (div_q >= half_m1) begin
                div_d = 9'h000;
                out_d = ~out_q;
            end else begin
                div_d = 9'(div_q + 9'h001);
            end
        end
        oe_d = gate_d | ctrl_d[CTRL_IDLE_BIT];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            gate_q <= 1'b0;
            out_q <= 1'b0;
            div_q <= 9'h000;
            oe_q <= 1'b0;
        end else begin
            gate_q <= gate_d;
            out_q <= out_d;
            div_q <= div_d;
            oe_q <= oe_d;
        end
    end

    assign clk_out_o = out_q;
    assign clk_out_oe = oe_q;
    assign osc_running_o = osc_running;

    // Helper counter for the power-down close time.
    logic [16:0] close_cnt;
    always_ff @(posedge clk) begin
        if (!resetn || state_q != ST_PWRDN || !gate_q) begin
            close_cnt <= 17'h0_0000;
        end else begin
            close_cnt <= 17'(close_cnt + 17'h0_0001);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_settle_end;
        state_q == ST_SETTLE && settle_q == SETTLE_LAST && pd_s;
    endsequence

    sequence s_gate_busy_off;
        gate_q && state_q == ST_PWRDN;
    endsequence

    a_dither_off_idle: assert property (!dith_act |-> !stall ##1 acc_q == 10'h000)
        else $error("divider stalled while dither is off");
    a_oe_drives: assert property (gate_q |-> clk_out_oe)
        else $error("output not driven while the gate is open");
    a_oe_keeps_osc: assert property (state_q == ST_RUN && !oe_s |-> osc_running_o)
        else $error("oscillator stopped by output enable");
    a_pdn_stops: assert property (!pd_s |=> state_q == ST_PWRDN)
        else $error("power-down pin low did not stop the oscillator");
    a_run_after_settle: assert property (s_settle_end |=> state_q == ST_RUN)
        else $error("settling did not end in run");
    a_settle_len: assert property ($rose(state_q == ST_RUN) |-> $past(settle_q) == SETTLE_LAST)
        else $error("settling delay is not 512 cycles");
    a_settle_bound: assert property (settle_q < STAB_MAX)
        else $error("re-enable delay exceeds its bound");
    a_pdn_close: assert property (s_gate_busy_off |-> ##[1:CLOSE_WAIT] !gate_q)
        else $error("output not disabled soon after power-down");
    a_pdn_limit: assert property (close_cnt < PDN_MAX)
        else $error("power-down disable time exceeded");
    a_down_only: assert property (gate_q && out_q != $past(out_q) && $past(gate_q) |-> $past(div_q) >= $past(half_m1))
        else $error("output half period shorter than undithered");
    a_glitch_free: assert property ($fell(gate_q) |-> !clk_out_o && !$past(out_q))
        else $error("gate closed during a high phase");
    a_first_edge: assert property ($rose(gate_q) |-> !out_q && div_q == 9'h000)
        else $error("gate opened with divider not cleared");
    a_idle_drive: assert property (!gate_q |-> clk_out_oe == ctrl_q[CTRL_IDLE_BIT] && !clk_out_o)
        else $error("idle output drive does not follow setting");
    a_prescale_clamp: assert property (exp_raw > EXP_MAX |-> half_m1 == 9'h0FF)
        else $error("prescale exponent above 8 not clamped");
endmodule // dcoc_top

//--- dcoc_pin_ctrl.sv
// Model of the external controller that drives the level control pins.
`timescale 1ns/100ps
module dcoc_pin_ctrl #(
    parameter int PD_HOLD = 1008
) (
    input wire logic clk,
    input wire logic dith_req,
    input wire logic oe_req,
    input wire logic run_req,
    output logic dither_enable_pin,
    output logic output_enable_pin,
    output logic power_down_pin
);
    int hold_cnt = 0;
    // The low level from power-up is not a request, so it needs no hold.
    bit armed = 1'b0;
    initial begin
        dither_enable_pin = 1'b0;
        output_enable_pin = 1'b0;
        power_down_pin = 1'b0;
    end
    // A power-down pulse is held low for at least PD_HOLD cycles before release.
    always @(posedge clk) begin
        dither_enable_pin <= dith_req;
        output_enable_pin <= oe_req;
        hold_cnt <= power_down_pin ? 0 : hold_cnt + 1;
        armed <= armed | power_down_pin;
        if (!armed || power_down_pin || hold_cnt >= PD_HOLD) begin
            power_down_pin <= run_req;
        end
    end
endmodule // dcoc_pin_ctrl

//--- tb_dithered_clock_output_control.sv
// Self-checking testbench for the dithered clock output control.
`timescale 1ns/100ps
module tb_dithered_clock_output_control
    import dcoc_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic dith_req = 1'b0;
    logic oe_req = 1'b0;
    logic run_req = 1'b0;
    logic dith_pin, oe_pin, pd_pin, clk_out_o, clk_out_oe, osc_running_o;
    int n_fail = 0;
    int compares = 0;
    int n, cnt, rmin, rmax;

    always #5 clk = ~clk;

    dcoc_pin_ctrl i_ctrl (.clk(clk), .dith_req(dith_req), .oe_req(oe_req),
        .run_req(run_req), .dither_enable_pin(dith_pin),
        .output_enable_pin(oe_pin), .power_down_pin(pd_pin));

    dcoc_top #(.STAB_MAX(600), .PDN_MAX(400)) i_dut (.clk(clk),
        .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dither_enable_pin(dith_pin), .output_enable_pin(oe_pin),
        .power_down_pin(pd_pin), .clk_out_o(clk_out_o),
        .clk_out_oe(clk_out_oe), .osc_running_o(osc_running_o));

    task end_of_test();
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waitrequest is sampled mid-cycle; it cannot change before the edge.
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
             output logic [31:0] q);
        logic done;
        done = 1'b0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        while (!done) begin
            @(negedge clk);
            done = (avs_waitrequest === 1'b0);
            q = avs_readdata;
            @(posedge clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // One idle edge keeps a following call from re-raising the strobe.
        @(posedge clk);
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(what, q, exp);
    endtask

    function automatic logic pick(input int sel);
        return sel == 0 ? clk_out_oe : (sel == 1 ? clk_out_o : osc_running_o);
    endfunction

    task pin(input string what, input int sel, input logic exp);
        @(negedge clk);
        chk(what, 32'(pick(sel)), 32'(exp));
        @(posedge clk);
    endtask

    task wait_lvl(input int sel, input logic lvl, input int lim);
        n = 0;
        @(negedge clk);
        while (pick(sel) !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask

    // Run lengths of clk_out_o; the partial runs at both ends are ignored.
    task runs(input int ncyc);
        logic prev;
        int len;
        bit first;
        cnt = 0;
        rmin = 9999;
        rmax = 0;
        len = 0;
        first = 1'b1;
        @(negedge clk);
        prev = clk_out_o;
        repeat (ncyc) begin
            @(negedge clk);
            len++;
            if (clk_out_o !== prev) begin
                if (!first) begin
                    rmin = len < rmin ? len : rmin;
                    rmax = len > rmax ? len : rmax;
                end
                first = 1'b0;
                len = 0;
                cnt++;
            end
            prev = clk_out_o;
        end
        @(posedge clk);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(CTRL_OFS, CTRL_RST, "ctrl reset");
        rd(STAT_OFS, 32'h0000_0001, "status reset");
        rd(4'h8, 32'h0000_0000, "unmapped read");
        wr(4'h8, 32'hFFFF_FFFF);
        wr(STAT_OFS, 32'hFFFF_FFFF);
        wr(CTRL_OFS, 32'hFFFF_FFF9);
        rd(CTRL_OFS, 32'h0000_0039, "ctrl mask");
        rd(STAT_OFS, 32'h0000_0001, "status ro");
        pin("idle drive low", 0, 1'b1);
        wr(CTRL_OFS, 32'h0000_0009);
        pin("idle float", 0, 1'b0);
        run_req <= 1'b1;
        oe_req <= 1'b1;
        wait_lvl(0, 1'b1, 600);
        chk("settle", 32'(n >= 513 && n <= 530), 1);
        runs(1100);
        chk("clamp min", rmin, 256);
        chk("clamp max", rmax, 256);
        wr(CTRL_OFS, 32'h0000_0001);
        runs(4096);
        chk("plain count", cnt, 2048);
        chk("plain max", rmax, 2);
        rd(STAT_OFS, 32'h0000_002C, "status run");
        dith_req <= 1'b1;
        repeat (8) @(posedge clk);
        rd(STAT_OFS, 32'h0000_003C, "status dither");
        runs(4096);
        chk("dither min", rmin, 2);
        chk("dither max", rmax, 3);
        chk("dither count", 32'(cnt < 2048 && cnt > 1940), 1);
        dith_req <= 1'b0;
        oe_req <= 1'b0;
        wait_lvl(0, 1'b0, 40);
        chk("gate close", 32'(n < 40), 1);
        runs(200);
        chk("gated count", cnt, 0);
        pin("osc on", 2, 1'b1);
        wr(CTRL_OFS, 32'h0000_0021);
        pin("gated drive", 0, 1'b1);
        wr(CTRL_OFS, 32'h0000_0001);
        oe_req <= 1'b1;
        wait_lvl(0, 1'b1, 40);
        run_req <= 1'b0;
        wait_lvl(2, 1'b0, 400);
        chk("pd stop", 32'(n < 400), 1);
        pin("pd float", 0, 1'b0);
        rd(STAT_OFS, 32'h0000_0001, "status pd");
        run_req <= 1'b1;
        wait_lvl(0, 1'b1, 1700);
        chk("pd exit", 32'(n < 1700), 1);
        end_of_test();
    end
endmodule // tb_dithered_clock_output_control
